// File: shared/tpg_timing_pkg.sv
// Purpose: constants for the test pattern frame and line timing block
// Assumes: 200 MHz core clock, byte-wide indirect register port
// Notes:   16-bit values split high byte at lower offset, low byte next

package tpg_timing_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_BAR_HIGH     = 8'h06;
    localparam logic [7:0] OFF_BAR_LOW      = 8'h07;
    localparam logic [7:0] OFF_ACT_HIGH     = 8'h08;
    localparam logic [7:0] OFF_ACT_LOW      = 8'h09;
    localparam logic [7:0] OFF_TOT_HIGH     = 8'h0a;
    localparam logic [7:0] OFF_TOT_LOW      = 8'h0b;
    localparam logic [7:0] OFF_PER_HIGH     = 8'h0c;
    localparam logic [7:0] OFF_PER_LOW      = 8'h0d;
    localparam logic [7:0] OFF_BACK_PORCH   = 8'h0e;
    localparam logic [7:0] OFF_FRONT_PORCH  = 8'h0f;
    localparam logic [7:0] OFF_STATUS       = 8'h1e;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BAR_HIGH     = 8'h00;
    localparam logic [7:0] RST_BAR_LOW      = 8'hf0;
    localparam logic [7:0] RST_ACT_HIGH     = 8'h01;
    localparam logic [7:0] RST_ACT_LOW      = 8'he0;
    localparam logic [7:0] RST_TOT_HIGH     = 8'h02;
    localparam logic [7:0] RST_TOT_LOW      = 8'h0d;
    localparam logic [7:0] RST_PER_HIGH     = 8'h0c;
    localparam logic [7:0] RST_PER_LOW      = 8'h67;
    localparam logic [7:0] RST_BACK_PORCH   = 8'h21;
    localparam logic [7:0] RST_FRONT_PORCH  = 8'h0a;

    // status register fields
    localparam int STAT_IN_FRAME  = 0;
    localparam int STAT_IN_ACTIVE = 1;
    localparam int STAT_IN_LINE   = 2;

    // ------------------------------------------------------------------
    // lane rate codes
    // ------------------------------------------------------------------
    localparam logic [1:0] LANE_400M = 2'h0;
    localparam logic [1:0] LANE_800M = 2'h1;
    localparam logic [1:0] LANE_1G2  = 2'h2;
    localparam logic [1:0] LANE_1G6  = 2'h3;

    // ------------------------------------------------------------------
    // line period units as multiples of the core clock period
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int UNIT_FAST_PS    = 10000;
    localparam int UNIT_SLOW_PS    = 20000;
    // 13.33 ns is held exactly as 40/3 ns
    localparam int UNIT_MID_NUM_PS = 40000;
    localparam int UNIT_MID_DEN    = 3;

    localparam logic [3:0] CYC_FAST_NUM = 4'(UNIT_FAST_PS / CLK_PERIOD_PS);
    localparam logic [3:0] CYC_SLOW_NUM = 4'(UNIT_SLOW_PS / CLK_PERIOD_PS);
    localparam logic [3:0] CYC_MID_NUM  = 4'(UNIT_MID_NUM_PS / CLK_PERIOD_PS);
    localparam logic [3:0] CYC_MID_DEN  = 4'(UNIT_MID_DEN);
    localparam logic [3:0] CYC_ONE_DEN  = 4'h1;

    // ------------------------------------------------------------------
    // frame regions
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_BACK   = 5'b00010,
        ST_ACTIVE = 5'b00100,
        ST_FRONT  = 5'b01000,
        ST_FILL   = 5'b10000
    } frame_state_e;

endpackage

// File: design/line_tick_gen.sv
// Purpose: one-cycle pulse at every line period boundary
// Assumes: period given in lane-rate dependent units
// Notes:   fractional unit kept exact with a remainder accumulator

`timescale 1ns/1ps

module line_tick_gen
    import tpg_timing_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // control
    input  wire logic        run_i,
    input  wire logic [1:0]  lane_rate_i,
    input  wire logic [15:0] period_i,
    // event
    output logic             tick_o
);

    typedef struct packed {
        logic [3:0]  acc;
        logic [15:0] units;
        logic        tick;
    } tick_state_s;

    tick_state_s s_q;
    tick_state_s s_d;
    logic [3:0]  num;
    logic [3:0]  den;
    logic [4:0]  acc_sum;

    always_comb begin
        case (lane_rate_i)
            LANE_400M: begin
                num = CYC_SLOW_NUM;
                den = CYC_ONE_DEN;
            end
            LANE_1G2: begin
                num = CYC_MID_NUM;
                den = CYC_MID_DEN;
            end
            default: begin
                num = CYC_FAST_NUM;
                den = CYC_ONE_DEN;
            end
        endcase
        acc_sum = {1'b0, s_q.acc} + {1'b0, den};
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run_i) begin
            s_d.acc = 4'h0;
            s_d.units = 16'h0000;
        end else if (acc_sum >= {1'b0, num}) begin
            s_d.acc = 4'(acc_sum - {1'b0, num});
            // a zero period behaves as one unit
            if (s_q.units + 16'h0001 >= period_i) begin
                s_d.units = 16'h0000;
                s_d.tick = 1'b1;
            end else begin
                s_d.units = s_q.units + 16'h0001;
            end
        end else begin
            s_d.acc = acc_sum[3:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;

endmodule

// File: design/tpg_frame_timing.sv
// Purpose: frame and line timing of the test pattern generator
// Assumes: byte-wide indirect register port, one byte per clock when active
// Notes:   timing values are shadowed at each frame start

`timescale 1ns/1ps

module tpg_frame_timing
    import tpg_timing_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o,
    // neighbouring generator settings
    input  wire logic        generator_on_i,
    input  wire logic [15:0] active_line_bytes_i,
    input  wire logic [3:0]  bar_count_i,
    input  wire logic [1:0]  lane_rate_i,
    // frame and line events toward the transmit port
    output logic             frame_start_o,
    output logic             frame_end_o,
    output logic             line_start_o,
    output logic             byte_valid_o,
    output logic             byte_last_o,
    output logic [2:0]       bar_index_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]  bar_length;
        logic [15:0]  active_line_count;
        logic [15:0]  total_line_count;
        logic [15:0]  line_period;
        logic [7:0]   back_porch_count;
        logic [7:0]   front_porch_count;
        logic [15:0]  sh_bar;
        logic [15:0]  sh_act;
        logic [15:0]  sh_tot;
        logic [15:0]  sh_period;
        logic [7:0]   sh_back;
        logic [7:0]   sh_front;
        logic [15:0]  sh_bytes;
        logic [2:0]   sh_last_bar;
        frame_state_e state;
        logic [16:0]  line_no;
        logic [15:0]  bytes_left;
        logic [15:0]  bar_pos;
        logic [2:0]   bar_idx;
        logic [7:0]   rdata;
        logic         fs;
        logic         fe;
        logic         ls;
        logic         bv;
        logic         bl;
    } timing_state_s;

    timing_state_s s_q;
    timing_state_s s_d;
    logic          tick;
    logic          running;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic frame_state_e region(input logic [16:0] ln, input logic [16:0] back,
                                            input logic [16:0] act, input logic [16:0] front);
        if (ln < back) begin
            region = ST_BACK;
        end else if (ln < back + act) begin
            region = ST_ACTIVE;
        end else if (ln < back + act + front) begin
            region = ST_FRONT;
        end else begin
            region = ST_FILL;
        end
    endfunction

    // byte at one offset of a 16-bit value, high byte first
    function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
        pick = hi ? v[15:8] : v[7:0];
    endfunction

    assign running = (s_q.state != ST_IDLE);

    line_tick_gen u_tick (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .run_i       (generator_on_i),
        .lane_rate_i (lane_rate_i),
        .period_i    (s_q.sh_period),
        .tick_o      (tick)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [16:0] back;
        logic [16:0] act;
        logic [16:0] front;
        logic [16:0] fe_line;
        logic [16:0] frame_len;
        logic [16:0] nxt_line;
        logic        new_frame;
        logic        new_line;
        back = 17'h0_0000;
        act = 17'h0_0000;
        front = 17'h0_0000;
        fe_line = 17'h0_0000;
        frame_len = 17'h0_0000;
        nxt_line = 17'h0_0000;
        new_frame = 1'b0;
        new_line = 1'b0;
        s_d = s_q;
        s_d.fs = 1'b0;
        s_d.fe = 1'b0;
        s_d.ls = 1'b0;
        s_d.bv = 1'b0;
        s_d.bl = 1'b0;

        // register port
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFF_BAR_HIGH:    s_d.bar_length[15:8] = reg_wdata_i;
                OFF_BAR_LOW:     s_d.bar_length[7:0] = reg_wdata_i;
                OFF_ACT_HIGH:    s_d.active_line_count[15:8] = reg_wdata_i;
                OFF_ACT_LOW:     s_d.active_line_count[7:0] = reg_wdata_i;
                OFF_TOT_HIGH:    s_d.total_line_count[15:8] = reg_wdata_i;
                OFF_TOT_LOW:     s_d.total_line_count[7:0] = reg_wdata_i;
                OFF_PER_HIGH:    s_d.line_period[15:8] = reg_wdata_i;
                OFF_PER_LOW:     s_d.line_period[7:0] = reg_wdata_i;
                OFF_BACK_PORCH:  s_d.back_porch_count = reg_wdata_i;
                OFF_FRONT_PORCH: s_d.front_porch_count = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFF_BAR_HIGH:    s_d.rdata = pick(s_q.bar_length, 1'b1);
                OFF_BAR_LOW:     s_d.rdata = pick(s_q.bar_length, 1'b0);
                OFF_ACT_HIGH:    s_d.rdata = pick(s_q.active_line_count, 1'b1);
                OFF_ACT_LOW:     s_d.rdata = pick(s_q.active_line_count, 1'b0);
                OFF_TOT_HIGH:    s_d.rdata = pick(s_q.total_line_count, 1'b1);
                OFF_TOT_LOW:     s_d.rdata = pick(s_q.total_line_count, 1'b0);
                OFF_PER_HIGH:    s_d.rdata = pick(s_q.line_period, 1'b1);
                OFF_PER_LOW:     s_d.rdata = pick(s_q.line_period, 1'b0);
                OFF_BACK_PORCH:  s_d.rdata = s_q.back_porch_count;
                OFF_FRONT_PORCH: s_d.rdata = s_q.front_porch_count;
                OFF_STATUS: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[STAT_IN_FRAME] = running;
                    s_d.rdata[STAT_IN_ACTIVE] = (s_q.state == ST_ACTIVE);
                    s_d.rdata[STAT_IN_LINE] = (s_q.bytes_left != 16'h0000);
                end
                default:         s_d.rdata = 8'h00;
            endcase
        end

        // line sequencing
        back = {9'h000, s_q.sh_back};
        act = {1'b0, s_q.sh_act};
        front = {9'h000, s_q.sh_front};
        fe_line = back + act + front;
        // total shorter than the porches plus video still leaves room for frame end
        frame_len = ({1'b0, s_q.sh_tot} > fe_line) ? {1'b0, s_q.sh_tot}
                                                    : fe_line + 17'h0_0001;

        if (!generator_on_i) begin
            // stopping is immediate; a frame in flight is dropped without frame end
            s_d.state = ST_IDLE;
            s_d.line_no = 17'h0_0000;
            s_d.bytes_left = 16'h0000;
        end else begin
            if (s_q.state == ST_IDLE) begin
                new_frame = 1'b1;
            end else if (tick) begin
                nxt_line = s_q.line_no + 17'h0_0001;
                if (nxt_line >= frame_len) begin
                    new_frame = 1'b1;
                end else begin
                    new_line = 1'b1;
                end
            end

            if (new_frame) begin
                // shadow copies keep the running frame consistent
                s_d.sh_bar = s_q.bar_length;
                s_d.sh_act = s_q.active_line_count;
                s_d.sh_tot = s_q.total_line_count;
                s_d.sh_period = s_q.line_period;
                s_d.sh_back = s_q.back_porch_count;
                s_d.sh_front = s_q.front_porch_count;
                s_d.sh_bytes = active_line_bytes_i;
                s_d.sh_last_bar = (bar_count_i == 4'h0) ? 3'h0 : 3'(bar_count_i - 4'h1);
                s_d.fs = 1'b1;
                s_d.line_no = 17'h0_0000;
                s_d.state = region(17'h0_0000, {9'h000, s_q.back_porch_count},
                                   {1'b0, s_q.active_line_count},
                                   {9'h000, s_q.front_porch_count});
            end else if (new_line) begin
                s_d.line_no = nxt_line;
                s_d.state = region(nxt_line, back, act, front);
                s_d.fe = (nxt_line == fe_line);
            end

            if ((new_frame || new_line) && (s_d.state == ST_ACTIVE)) begin
                s_d.ls = 1'b1;
                s_d.bytes_left = new_frame ? active_line_bytes_i : s_q.sh_bytes;
                s_d.bar_pos = 16'h0000;
                s_d.bar_idx = 3'h0;
            end else if (s_q.bytes_left != 16'h0000) begin
                // a line longer than its period is cut at the next line start
                s_d.bv = 1'b1;
                s_d.bl = (s_q.bytes_left == 16'h0001);
                s_d.bytes_left = s_q.bytes_left - 16'h0001;
                // bar_pos counts bytes already sent in bar bar_idx
                if ((s_q.bar_pos != 16'h0000) && (s_q.bar_pos >= s_q.sh_bar) &&
                    (s_q.bar_idx != s_q.sh_last_bar)) begin
                    s_d.bar_pos = 16'h0001;
                    s_d.bar_idx = s_q.bar_idx + 3'h1;
                end else begin
                    // final bar runs on to the end of the line
                    s_d.bar_pos = s_q.bar_pos + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.bar_length <= {RST_BAR_HIGH, RST_BAR_LOW};
            s_q.active_line_count <= {RST_ACT_HIGH, RST_ACT_LOW};
            s_q.total_line_count <= {RST_TOT_HIGH, RST_TOT_LOW};
            s_q.line_period <= {RST_PER_HIGH, RST_PER_LOW};
            s_q.back_porch_count <= RST_BACK_PORCH;
            s_q.front_porch_count <= RST_FRONT_PORCH;
            s_q.state <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // bar index and byte strobe leave the same flop stage, so they always agree
    assign reg_rdata_o = s_q.rdata;
    assign frame_start_o = s_q.fs;
    assign frame_end_o = s_q.fe;
    assign line_start_o = s_q.ls;
    assign byte_valid_o = s_q.bv;
    assign byte_last_o = s_q.bl;
    assign bar_index_o = s_q.bar_idx;

endmodule

// File: tb/tpg_frame_timing_asserts.sv
// Purpose: concurrent checks on the ports of the frame timing block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of tpg_frame_timing
`timescale 1ns/1ps
module tpg_frame_timing_asserts
    import tpg_timing_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // register port
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // frame stream
    input wire logic       generator_on_i,
    input wire logic       frame_start_o,
    input wire logic       frame_end_o,
    input wire logic       line_start_o,
    input wire logic       byte_valid_o,
    input wire logic       byte_last_o,
    input wire logic [2:0] bar_index_o
);
    // ----------------------------------------------------------------
    // stream and register port checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_off_is_quiet: assert property (!generator_on_i |=> !byte_valid_o && !line_start_o
        && !frame_start_o && !frame_end_o) else $error("activity while generator off");
    a_start_needs_on: assert property (frame_start_o |-> $past(generator_on_i))
        else $error("frame start without enable");
    a_start_is_pulse: assert property (frame_start_o |=> !frame_start_o)
        else $error("frame start longer than one cycle");
    a_last_ends_line: assert property (byte_last_o |-> byte_valid_o ##1 !byte_valid_o)
        else $error("last byte not closing the line");
    a_line_has_bytes: assert property (line_start_o && generator_on_i |=> byte_valid_o)
        else $error("no byte after line start");
    a_first_bar_zero: assert property (byte_valid_o && $past(line_start_o)
        |-> bar_index_o == 3'h0) else $error("line does not begin in bar zero");
    a_bar_steps_up: assert property (byte_valid_o && $past(byte_valid_o)
        |-> bar_index_o - $past(bar_index_o) <= 1) else $error("bar index jumped");
    a_end_is_blank: assert property (frame_end_o |-> !byte_valid_o && !line_start_o)
        else $error("frame end during video");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    c_frame_end: cover property (frame_end_o);
    c_last_byte: cover property (byte_last_o);
    c_abort: cover property (byte_valid_o ##1 !generator_on_i);
endmodule

bind tpg_frame_timing tpg_frame_timing_asserts tpg_frame_timing_asserts_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .generator_on_i(generator_on_i), .frame_start_o(frame_start_o),
    .frame_end_o(frame_end_o), .line_start_o(line_start_o), .byte_valid_o(byte_valid_o),
    .byte_last_o(byte_last_o), .bar_index_o(bar_index_o));

// File: tb/tx_sink_model.sv
// Purpose: transmit-port side model that tallies frame events
// Assumes: events are one-cycle pulses from the timing block
// Notes:   counts only; the bench judges the framing from the tallies
`timescale 1ns/1ps
module tx_sink_model (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    // events from the block
    input  wire logic   frame_start_i,
    input  wire logic   frame_end_i,
    input  wire logic   line_start_i,
    input  wire logic   byte_valid_i,
    input  wire logic   byte_last_i,
    // tallies
    output logic [15:0] fe_cnt_o,
    output logic [15:0] ls_cnt_o,
    output logic [15:0] line_len_o
);
    typedef struct packed {
        logic [15:0] fe;
        logic [15:0] ls;
        logic [15:0] run;
        logic [15:0] len;
    } tally_s;
    tally_s tally_q;
    tally_s tally_d;

    always_comb begin
        tally_d = tally_q;
        if (frame_end_i) tally_d.fe = tally_q.fe + 16'h0001;
        if (line_start_i) tally_d.ls = tally_q.ls + 16'h0001;
        // an aborted line must not leak its bytes into the next count
        if (frame_start_i || line_start_i) tally_d.run = 16'h0000;
        if (byte_valid_i) tally_d.run = tally_q.run + 16'h0001;
        if (byte_valid_i && byte_last_i) tally_d.len = tally_q.run + 16'h0001;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) tally_q <= '0;
        else tally_q <= tally_d;
    end

    assign fe_cnt_o   = tally_q.fe;
    assign ls_cnt_o   = tally_q.ls;
    assign line_len_o = tally_q.len;
endmodule

// File: tb/tpg_frame_timing_tb.sv
// Purpose: self-checking bench for the frame timing block
// Assumes: 200 MHz clock, inputs driven on the falling edge
// Notes:   small register values keep a frame to a few hundred cycles
`timescale 1ns/1ps
module tpg_frame_timing_tb
    import tpg_timing_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        generator_on_i = 1'b0;
    logic [15:0] active_line_bytes_i = 16'h000e;
    logic [3:0]  bar_count_i = 4'h4;
    logic [1:0]  lane_rate_i = LANE_800M;
    logic [7:0]  reg_rdata_o;
    logic        frame_start_o, frame_end_o, line_start_o, byte_valid_o, byte_last_o;
    logic [2:0]  bar_index_o;
    logic [15:0] fe_cnt, ls_cnt, line_len;
    int          err_total = 0;
    int          checks_done = 0;

    always #2.5 clk_i = ~clk_i;

    tpg_frame_timing tpg_frame_timing_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .generator_on_i(generator_on_i),
        .active_line_bytes_i(active_line_bytes_i), .bar_count_i(bar_count_i),
        .lane_rate_i(lane_rate_i), .frame_start_o(frame_start_o),
        .frame_end_o(frame_end_o), .line_start_o(line_start_o),
        .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o), .bar_index_o(bar_index_o));

    tx_sink_model tx_sink_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .frame_start_i(frame_start_o), .frame_end_i(frame_end_o),
        .line_start_i(line_start_o), .byte_valid_i(byte_valid_o), .byte_last_i(byte_last_o),
        .fe_cnt_o(fe_cnt), .ls_cnt_o(ls_cnt), .line_len_o(line_len));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 8'h01, v[7:0]);
    endtask

    // bars of 3 bytes, total 10 lines, period 9 units, front porch 1
    task automatic setup(input logic [7:0] vbp, input logic [15:0] act);
        wr16(OFF_BAR_HIGH, 16'h0003);
        wr16(OFF_ACT_HIGH, act);
        wr16(OFF_TOT_HIGH, 16'h000a);
        wr16(OFF_PER_HIGH, 16'h0009);
        wr(OFF_BACK_PORCH, vbp);
        wr(OFF_FRONT_PORCH, 8'h01);
    endtask

    // cycles from a frame start to first line, frame end and next start
    task automatic meas(output int t_ls, output int t_fe, output int t_fs,
                        output logic [15:0] n_ls);
        int          n;
        logic [15:0] ls0;
        t_ls = -1;
        t_fe = -1;
        t_fs = -1;
        n = 0;
        @(negedge clk_i);
        while (frame_start_o !== 1'b1 && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        ls0 = ls_cnt;
        for (int c = 1; c < 5000 && t_fs < 0; c++) begin
            @(negedge clk_i);
            if (line_start_o === 1'b1 && t_ls < 0) t_ls = c;
            if (frame_end_o === 1'b1) t_fe = c;
            if (frame_start_o === 1'b1) t_fs = c;
        end
        n_ls = ls_cnt - ls0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_regs;
        logic [7:0] exp [9];
        logic [7:0] d;
        exp = '{8'hf0, 8'h01, 8'he0, 8'h02, 8'h0d, 8'h0c, 8'h67, 8'h21, 8'h0a};
        for (int k = 0; k < 9; k++) begin
            rd(8'h07 + 8'(k), d);
            chk("reset value", exp[k], d);
            wr(8'h07 + 8'(k), 8'h5a ^ 8'(k));
            rd(8'h07 + 8'(k), d);
            chk("readback", 8'h5a ^ 8'(k), d);
        end
        rd(8'h30, d);
        chk("unmapped read", 8'h00, d);
    endtask

    task automatic t_frame_shape;
        int          t_ls, t_fe, t_fs;
        logic [15:0] n_ls;
        setup(8'h02, 16'h0003);
        generator_on_i = 1'b1;
        meas(t_ls, t_fe, t_fs, n_ls);
        chk("back porch cycles", 36, t_ls);
        chk("frame end cycles", 108, t_fe);
        chk("frame cycles", 180, t_fs);
        chk("lines per frame", 3, n_ls);
        chk("line bytes", 14, line_len);
    endtask

    // 14 bytes in bars of 3 over 4 bars: the last bar takes 5
    task automatic t_bars;
        int n;
        n = 0;
        while (line_start_o !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        for (int i = 0; i < 14; i++) begin
            @(negedge clk_i);
            chk("byte valid", 1, byte_valid_o);
            chk("bar index", (i < 9) ? i / 3 : 3, bar_index_o);
            chk("last byte", i == 13, byte_last_o);
        end
    endtask

    task automatic t_lanes;
        int          t_ls, t_fe, t_fs;
        logic [15:0] n_ls;
        int          cyc [4];
        cyc = '{36, 18, 24, 18};
        for (int r = 0; r < 4; r++) begin
            lane_rate_i = 2'(r);
            meas(t_ls, t_fe, t_fs, n_ls);
            meas(t_ls, t_fe, t_fs, n_ls);
            chk("lane frame cycles", 10 * cyc[r], t_fs);
        end
        lane_rate_i = LANE_800M;
    endtask

    task automatic t_midframe;
        int          t_ls, t_fe, t_fs;
        logic [15:0] n_ls;
        fork
            meas(t_ls, t_fe, t_fs, n_ls);
            begin
                @(posedge frame_start_o);
                repeat (10) @(negedge clk_i);
                wr(OFF_BACK_PORCH, 8'h04);
            end
        join
        chk("current back porch", 36, t_ls);
        chk("current frame end", 108, t_fe);
        meas(t_ls, t_fe, t_fs, n_ls);
        chk("next back porch", 72, t_ls);
        chk("next frame end", 144, t_fe);
    endtask

    task automatic t_enable_off;
        logic [15:0] fe0;
        int          n;
        logic [7:0]  d;
        n = 0;
        while (byte_valid_o !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        fe0 = fe_cnt;
        generator_on_i = 1'b0;
        @(negedge clk_i);
        chk("bytes after off", 0, byte_valid_o);
        n = 0;
        repeat (400) begin
            @(negedge clk_i);
            if (frame_start_o !== 1'b0) n++;
        end
        chk("starts while off", 0, n);
        chk("frame end on abort", fe0, fe_cnt);
        rd(OFF_STATUS, d);
        chk("status while off", 8'h00, d);
        generator_on_i = 1'b1;
        @(negedge clk_i);
        chk("start after on", 1, frame_start_o);
    endtask

    task automatic results;
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset_regs();
        t_frame_shape();
        t_bars();
        t_lanes();
        t_midframe();
        t_enable_off();
        results();
    end

    // about four times the expected length of the run
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule
